// File: rtl/tec_trigger_exposure.sv
// Exposure and readout sequencer: free run, partial scan, random trigger, restart/reset.
// Assumes all inputs synchronous to clk_i; the line period is counted directly in clk_i cycles, with no pixel clock enable.
`timescale 1ns/1ps
`include "tec_regs.svh"

module tec_trigger_exposure (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control line CC1: trigger or frame sync
  input wire logic trigger_or_frame_sync_in_i,
  // Configuration
  input wire logic trig_enable_i,
  input wire logic trig_pulse_width_i,
  input wire logic restart_enable_i,
  input wire logic trig_pol_pos_i,
  input wire logic pol_load_i,
  input wire logic partial_enable_i,
  input wire logic [10:0] partial_start_i,
  input wire logic [10:0] partial_width_i,
  input wire logic partial_update_i,
  input wire logic [23:0] shutter_lines_i,
  // Status and sequencing outputs
  output logic line_tick_o,
  output logic exposing_o,
  output logic frame_valid_o,
  output logic line_valid_o,
  output logic [10:0] line_index_o,
  output logic [1:0] mode_o,
  output logic trig_pol_pos_o,
  output logic partial_reject_o
);

  // Line period in clk_i cycles: 1920 pixel clocks at 36 MHz seen from 200 MHz, rounded down
  localparam int unsigned PIX_HZ = 36000000;
  localparam int unsigned CLK_HZ = 200000000;
  localparam longint unsigned LINE_CYC = (64'(`TEC_LINE_PIXCLK) * CLK_HZ) / PIX_HZ;
  localparam logic [13:0] LINE_LAST = 14'(LINE_CYC - 1);

  logic [13:0] line_cnt_q;
  logic line_tick;
  logic pol_q;
  logic cc1_q;
  logic act_now;
  logic act_q;
  logic pol_settle_q;
  logic start_ev;
  logic end_ev;
  tec_pkg::tec_mode_e mode_q;
  tec_pkg::tec_state_e state_q;
  logic [23:0] exp_cnt_q;
  logic [10:0] vline_q;
  logic [10:0] band_start_q;
  logic [10:0] band_width_q;
  logic reject_q;

  function automatic logic in_band(input logic [10:0] ln, input logic [10:0] st,
                                   input logic [10:0] wd);
    logic [11:0] hi;
    hi = 12'(st) + 12'(wd);
    in_band = (12'(ln) >= 12'(st)) && (12'(ln) < hi);
  endfunction

  // The count is taken before the closing tick adds its line, so that tick is included
  function automatic logic shutter_done(input logic [23:0] cnt, input logic [23:0] lim);
    shutter_done = (cnt + 24'h000001) >= lim;
  endfunction

  // Trigger wins when both are asked, so the two modes can never run at once
  function automatic tec_pkg::tec_mode_e pick_mode(input logic trig, input logic restart);
    if (trig) begin
      pick_mode = tec_pkg::TEC_MODE_TRIG;
    end else if (restart) begin
      pick_mode = tec_pkg::TEC_MODE_RESTART;
    end else begin
      pick_mode = tec_pkg::TEC_MODE_NORMAL;
    end
  endfunction

  function automatic logic last_line(input logic [10:0] ln);
    last_line = (ln == `TEC_VIDEO_LINES - 11'h001);
  endfunction

  // Line timebase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_cnt_q <= 14'h0000;
    end else if (line_cnt_q == LINE_LAST) begin
      line_cnt_q <= 14'h0000; // [R11]
    end else begin
      line_cnt_q <= line_cnt_q + 14'h0001;
    end
  end
  assign line_tick = (line_cnt_q == LINE_LAST);

  // Polarity; negative out of reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pol_q <= `TEC_POL_DEFAULT; // [R12]
    end else if (pol_load_i) begin
      pol_q <= trig_pol_pos_i; // [R12]
    end
  end

  // Only CC1 drives triggers and frame sync; active level follows polarity
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cc1_q <= 1'b1;
      act_q <= 1'b0;
      pol_settle_q <= 1'b0;
    end else begin
      cc1_q <= trigger_or_frame_sync_in_i; // [R1] [R6]
      act_q <= act_now;
      pol_settle_q <= pol_load_i;
    end
  end
  assign act_now = (pol_q == `TEC_POL_POS) ? cc1_q : ~cc1_q; // [R2] [R15]
  // A polarity load flips the active level of an idle line; that flip is not an edge,
  // so both edge events are masked for the one cycle act_q needs to catch up
  assign start_ev = act_now & ~act_q & ~pol_settle_q; // [R2] [R15]
  assign end_ev = ~act_now & act_q & ~pol_settle_q; // [R5] [R15]

  // Mode select: trigger wins if both asked; mode changes only while idle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= tec_pkg::TEC_MODE_NORMAL;
    end else if (state_q == tec_pkg::TEC_ST_IDLE) begin
      mode_q <= pick_mode(trig_enable_i, restart_enable_i); // [R3]
    end
  end

  // Partial window: loaded on update, refused below 600 lines or past the array
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      band_start_q <= `TEC_START_DEFAULT;
      band_width_q <= `TEC_WIDTH_DEFAULT;
      reject_q <= 1'b0;
    end else if (partial_update_i) begin
      if (partial_width_i >= `TEC_PARTIAL_MIN &&
          12'(partial_start_i) + 12'(partial_width_i) <= 12'(`TEC_VIDEO_LINES)) begin
        band_start_q <= partial_start_i; // [R13]
        band_width_q <= partial_width_i; // [R13]
        reject_q <= 1'b0;
      end else begin
        reject_q <= 1'b1; // [R13]
      end
    end
  end

  // Sequencer: exposure then readout of the sensor lines
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= tec_pkg::TEC_ST_IDLE;
    end else begin
      case (state_q)
        tec_pkg::TEC_ST_IDLE: begin
          if (mode_q == tec_pkg::TEC_MODE_NORMAL && line_tick) begin
            state_q <= tec_pkg::TEC_ST_EXPOSE;
          end else if (mode_q != tec_pkg::TEC_MODE_NORMAL && start_ev) begin
            state_q <= tec_pkg::TEC_ST_EXPOSE; // [R1] [R6]
          end
        end
        tec_pkg::TEC_ST_EXPOSE: begin
          case (mode_q)
            tec_pkg::TEC_MODE_TRIG: begin
              if (trig_pulse_width_i) begin
                if (end_ev) begin
                  state_q <= tec_pkg::TEC_ST_WAIT_LINE; // [R5]
                end
              end else if (line_tick && shutter_done(exp_cnt_q, shutter_lines_i)) begin
                state_q <= tec_pkg::TEC_ST_WAIT_LINE; // [R4]
              end
            end
            tec_pkg::TEC_MODE_RESTART: begin
              if (start_ev) begin
                state_q <= tec_pkg::TEC_ST_WAIT_LINE; // [R7]
              end
            end
            default: begin
              // Free run clamps the shutter to one frame
              if (line_tick && (shutter_done(exp_cnt_q, shutter_lines_i) ||
                  shutter_done(exp_cnt_q, `TEC_FRAME_LINES))) begin
                state_q <= tec_pkg::TEC_ST_WAIT_LINE; // [R10]
              end
            end
          endcase
        end
        tec_pkg::TEC_ST_WAIT_LINE: begin
          // Readout aligns to the next line boundary, so it starts within one line
          if (line_tick) begin
            state_q <= tec_pkg::TEC_ST_READOUT; // [R8]
          end
        end
        tec_pkg::TEC_ST_READOUT: begin
          if (line_tick && last_line(vline_q)) begin
            // Restart chains only while still asked for; otherwise the loop would never
            // pass through idle and a trigger request could not take over
            if (mode_q == tec_pkg::TEC_MODE_RESTART &&
                pick_mode(trig_enable_i, restart_enable_i) == tec_pkg::TEC_MODE_RESTART) begin
              state_q <= tec_pkg::TEC_ST_EXPOSE; // [R7]
            end else begin
              state_q <= tec_pkg::TEC_ST_IDLE; // [R3]
            end
          end
        end
        default: begin
          state_q <= tec_pkg::TEC_ST_IDLE;
        end
      endcase
    end
  end

  // Exposure length in lines; parked at zero outside exposure so every start counts from 0
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      exp_cnt_q <= 24'h000000;
    end else if (state_q != tec_pkg::TEC_ST_EXPOSE) begin
      exp_cnt_q <= 24'h000000;
    end else if (line_tick) begin
      exp_cnt_q <= exp_cnt_q + 24'h000001; // [R4]
    end
  end

  // Readout line counter; parked at zero outside readout
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vline_q <= 11'h000;
    end else if (state_q != tec_pkg::TEC_ST_READOUT) begin
      vline_q <= 11'h000;
    end else if (line_tick) begin
      if (last_line(vline_q)) begin
        vline_q <= 11'h000;
      end else begin
        vline_q <= vline_q + 11'h001;
      end
    end
  end

  // Outputs from flip-flops; each trails the sequencer state by one cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_valid_o <= 1'b0;
    end else begin
      frame_valid_o <= (state_q == tec_pkg::TEC_ST_READOUT);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_index_o <= 11'h000;
    end else begin
      line_index_o <= vline_q;
    end
  end

  // Lines outside the band are flushed without being sent; the frame keeps its full
  // length, trading frame rate for a timebase that never changes with the window
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_valid_o <= 1'b0;
    end else begin
      line_valid_o <= (state_q == tec_pkg::TEC_ST_READOUT) &&
                      (!partial_enable_i || in_band(vline_q, band_start_q, band_width_q)); // [R9]
    end
  end

  assign line_tick_o = line_tick;
  assign exposing_o = (state_q == tec_pkg::TEC_ST_EXPOSE);
  assign mode_o = mode_q;
  assign trig_pol_pos_o = pol_q;
  assign partial_reject_o = reject_q;

endmodule

// File: rtl/tec_regs.svh
// Constants for the trigger and exposure sequencer: timing counts, field codes, reset values.
// Assumes a single 200 MHz clock; the line period is given in pixel clocks and converted to sequencer cycles by the sequencer.
// How it works
// R1 - In random trigger mode the trigger is taken only from control line CC1.
// R2 - With negative polarity exposure starts on the falling edge of the trigger.
// R3 - Random trigger and restart/reset never run together; enabling one excludes the other.
// R4 - In fixed trigger mode exposure length comes from the shutter setting, not the pulse.
// R5 - In pulse-width trigger mode exposure lasts exactly as long as the active trigger.
// R6 - In restart/reset mode the frame-sync pulses arrive on CC1 and are used as frame sync.
// R7 - In restart/reset mode exposure equals the interval between successive frame-sync pulses.
// R8 - In restart/reset mode image output starts within one line period after frame sync.
// R9 - In partial scan only the selected band of lines is read out; other lines are skipped.
// R10 - A normal full frame takes about 1/15 s and the shutter should not exceed it.
// R11 - One line period equals 1920 pixel clock cycles.
// R12 - Trigger polarity is selectable and negative is the reset default.
// R13 - A partial window is at least 600 lines tall, start and height set in single lines.
// R14 - The far side holds the trigger or frame-sync active between 8 us and 2 s.
// R15 - With positive polarity exposure starts on the rising edge; pulse-width ends on the other.
`ifndef TEC_REGS_SVH
`define TEC_REGS_SVH

// One line period: 1920 pixel clocks; the tick generator counts them in clk_i cycles
`define TEC_LINE_PIXCLK 1920
`define TEC_TOTAL_LINES 11'h4E0
`define TEC_VIDEO_LINES 11'h4B0
`define TEC_PARTIAL_MIN 11'h258
`define TEC_START_DEFAULT 11'h000
`define TEC_WIDTH_DEFAULT 11'h4B0
`define TEC_POL_NEG 1'b0
`define TEC_POL_POS 1'b1
`define TEC_POL_DEFAULT 1'b0
`define TEC_EXP_W 24
// Lines in one normal frame, the longest shutter for free run (about 1/15 s)
`define TEC_FRAME_LINES 24'h0004E0

`endif

// File: rtl/tec_pkg.sv
// Types shared by the trigger and exposure sequencer.
// Assumes tec_regs.svh is compiled alongside.
package tec_pkg;
  typedef enum logic [1:0] {
    TEC_MODE_NORMAL = 2'b00,
    TEC_MODE_TRIG = 2'b01,
    TEC_MODE_RESTART = 2'b10
  } tec_mode_e;

  typedef enum logic [2:0] {
    TEC_ST_IDLE = 3'b000,
    TEC_ST_EXPOSE = 3'b001,
    TEC_ST_WAIT_LINE = 3'b010,
    TEC_ST_READOUT = 3'b011
  } tec_state_e;
endpackage

// File: tb/tec_chk.sv
// Port checker for the trigger and exposure sequencer.
// Assumes one clock domain; bound to every sequencer instance below.
`timescale 1ns/1ps
module tec_chk (
  input wire logic clk_i, rst_i, trigger_or_frame_sync_in_i, trig_pulse_width_i,
  input wire logic trig_pol_pos_i, pol_load_i, partial_update_i, line_tick_o,
  input wire logic exposing_o, frame_valid_o, line_valid_o, trig_pol_pos_o,
  input wire logic partial_reject_o,
  input wire logic [10:0] partial_width_i,
  input wire logic [1:0] mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [13:0] gap_q;
  logic seen_q;
  logic act;
  assign act = trigger_or_frame_sync_in_i == trig_pol_pos_o;
  // The first tick after reset has no reference, so it is not measured
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) gap_q <= 14'h0000;
    else gap_q <= line_tick_o ? 14'h0000 : gap_q + 14'h0001;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) seen_q <= 1'b0;
    else if (line_tick_o) seen_q <= 1'b1;
  end
  line_period_a: assert property (line_tick_o && seen_q |-> gap_q == 14'h29A9)
    else $error("line period wrong");
  pol_load_a: assert property (pol_load_i |=> trig_pol_pos_o == $past(trig_pol_pos_i))
    else $error("polarity not loaded");
  mode_excl_a: assert property (mode_o != 2'h3)
    else $error("both trigger modes active");
  trig_start_a: assert property (mode_o == 2'h1 && !exposing_o && !frame_valid_o && $rose(act)
    |-> ##[1:3] exposing_o)
    else $error("trigger edge did not start exposure");
  pw_end_a: assert property ((mode_o == 2'h1 && trig_pulse_width_i && !act) [*3]
    |-> !exposing_o) else $error("exposure outlived pulse");
  pw_hold_a: assert property (mode_o == 2'h1 && trig_pulse_width_i && exposing_o && act
    |=> exposing_o) else $error("exposure ended inside pulse");
  band_gate_a: assert property (line_valid_o |-> frame_valid_o)
    else $error("line valid outside frame");
  reject_a: assert property (partial_update_i && partial_width_i < 11'h258
    |-> ##[1:2] partial_reject_o) else $error("short window accepted");
  cover property (mode_o == 2'h2 && $fell(exposing_o));
  cover property ($rose(frame_valid_o));
  cover property ($rose(partial_reject_o));
endmodule

bind tec_trigger_exposure tec_chk u_chk (.clk_i, .rst_i, .trigger_or_frame_sync_in_i,
  .trig_pulse_width_i, .trig_pol_pos_i, .pol_load_i, .partial_update_i, .line_tick_o,
  .exposing_o, .frame_valid_o, .line_valid_o, .trig_pol_pos_o, .partial_reject_o,
  .partial_width_i, .mode_o);

// File: tb/tec_cc1_model.sv
// Frame grabber side of control line CC1: trigger or frame-sync pulses.
// Assumes the bench keeps the polarity input equal to the loaded setting.
`timescale 1ns/1ps
module tec_cc1_model (
  input wire logic clk_i,
  input wire logic trig_pol_pos_i,
  output logic trigger_or_frame_sync_in_i
);
  // 8 us at 200 MHz; shorter requests are stretched to stay legal
  localparam int MinHold = 1600;
  logic act_q = 1'b0;
  assign trigger_or_frame_sync_in_i = act_q ? trig_pol_pos_i : !trig_pol_pos_i;
  task automatic pulse(input int len);
    @(posedge clk_i);
    #1 act_q = 1'b1;
    repeat (len < MinHold ? MinHold : len) @(posedge clk_i);
    #1 act_q = 1'b0;
  endtask
endmodule

// File: tb/tb.sv
// Bench for the trigger and exposure sequencer with a CC1 pulse model.
// Assumes about 67k cycles of run time.
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic rst_i, trigger_or_frame_sync_in_i, trig_enable_i, trig_pulse_width_i;
  logic restart_enable_i, trig_pol_pos_i, pol_load_i, partial_enable_i, partial_update_i;
  logic line_tick_o, exposing_o, frame_valid_o, line_valid_o, trig_pol_pos_o;
  logic partial_reject_o;
  logic [10:0] partial_start_i, partial_width_i, line_index_o;
  logic [23:0] shutter_lines_i;
  logic [1:0] mode_o;
  int err_total = 0;
  int checks_done = 0;
  int run_cnt, exp_len;
  always #2.5 clk_i = ~clk_i;
  tec_trigger_exposure dut (.*);
  tec_cc1_model u_cc1 (.*);
  // Length of the last finished exposure, sampled away from the active edge
  always @(negedge clk_i) begin
    if (exposing_o === 1'b1) run_cnt++;
    else if (run_cnt != 0) begin
      exp_len = run_cnt;
      run_cnt = 0;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic test_done();
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset();
    rst_i = 1'b1;
    {trig_enable_i, trig_pulse_width_i, restart_enable_i, trig_pol_pos_i} = 4'h0;
    {pol_load_i, partial_enable_i, partial_update_i} = 3'h0;
    partial_start_i = 11'h000;
    partial_width_i = 11'h4B0;
    shutter_lines_i = 24'h000002;
    step(6);
    rst_i = 1'b0;
    run_cnt = 0;
    exp_len = 0;
  endtask
  task automatic pw_case(input logic p);
    do_reset();
    check("pol_default", trig_pol_pos_o, 1'b0);
    trig_pol_pos_i = p;
    pol_load_i = 1'b1;
    step(1);
    pol_load_i = 1'b0;
    trig_enable_i = 1'b1;
    trig_pulse_width_i = 1'b1;
    step(4);
    check("pol_loaded", trig_pol_pos_o, p);
    check("mode_trig", mode_o, 2'h1);
    u_cc1.pulse(1600);
    step(4);
    check("pw_len", exp_len, 1600);
  endtask
  task automatic normal_case();
    do_reset();
    check("mode_norm", mode_o, 2'h0);
    for (int i = 0; i < 12000 && exposing_o !== 1'b1; i++) step(1);
    for (int i = 0; i < 23000 && exposing_o === 1'b1; i++) step(1);
    step(1);
    check("free_len", exp_len, 21332);
  endtask
  task automatic fixed_case();
    do_reset();
    trig_enable_i = 1'b1;
    restart_enable_i = 1'b1;
    step(4);
    check("mode_excl", mode_o, 2'h1);
    u_cc1.pulse(1600);
    for (int i = 0; i < 25000 && exposing_o === 1'b1; i++) step(1);
    step(1);
    check("fixed_min", exp_len > 10666, 1'b1);
    check("fixed_max", exp_len <= 21335, 1'b1);
  endtask
  task automatic partial_try(input logic [10:0] s, w, input logic r);
    partial_start_i = s;
    partial_width_i = w;
    partial_update_i = 1'b1;
    step(1);
    partial_update_i = 1'b0;
    step(2);
    check("part_reject", partial_reject_o, r);
  endtask
  task automatic restart_case();
    int lag;
    do_reset();
    partial_try(11'h000, 11'h257, 1'b1);
    partial_try(11'h259, 11'h258, 1'b1);
    partial_try(11'h258, 11'h258, 1'b0);
    partial_enable_i = 1'b1;
    restart_enable_i = 1'b1;
    step(4);
    check("mode_rst", mode_o, 2'h2);
    u_cc1.pulse(1600);
    step(1399);
    fork
      u_cc1.pulse(1600);
    join_none
    for (lag = 0; lag < 12000 && frame_valid_o !== 1'b1; lag++) step(1);
    check("band_skip", line_valid_o, 1'b0);
    check("line_index", line_index_o, 11'h000);
    wait fork;
    check("rst_len", exp_len, 3000);
    check("rst_lag", lag <= 10670, 1'b1);
  endtask
  initial begin
    normal_case();
    pw_case(1'b0);
    pw_case(1'b1);
    fixed_case();
    restart_case();
    test_done();
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    test_done();
  end
endmodule
